//--- common/fmmc_pkg.sv
package fmmc_pkg;
   // ****************************************
   // Clock and timing
   // ****************************************
   localparam int CLK_HZ          = 50000000;
   localparam int MARK_HZ         = 1200;
   localparam int SPACE_HZ        = 2200;
   localparam int TABLE_LEN       = 32;
   localparam int MARK_STEP_CYC   = CLK_HZ / (MARK_HZ * TABLE_LEN);
   localparam int SPACE_STEP_CYC  = CLK_HZ / (SPACE_HZ * TABLE_LEN);
   localparam int MAN_BAUD_HZ     = 31250;
   localparam int MAN_HALF_CYC    = CLK_HZ / (MAN_BAUD_HZ * 2);
   localparam int OSC_START_MS    = 50;
   localparam int OSC_START_CYC   = OSC_START_MS * (CLK_HZ / 1000);
   localparam int CNT_W           = 22;
   localparam int SAMPLE_W        = 6;
   localparam int IDX_W           = 5;
   localparam int FIFO_DEPTH      = 8;
   localparam int LVL_W           = 4;
   localparam int MAN_RX_TIMEOUT  = 4 * MAN_HALF_CYC;
   // Carrier hysteresis: counts of valid edges needed to assert and release.
   localparam logic [3:0] CD_ON_CNT  = 4'h6;
   localparam logic [3:0] CD_OFF_CNT = 4'h0;
   localparam logic [3:0] CD_MAX     = 4'hA;
   // Tone discrimination: half period in clock cycles above this is a mark.
   localparam int FSK_SPLIT_CYC   = CLK_HZ / (2 * 1700);
   localparam int FSK_MAX_CYC     = CLK_HZ / (2 * 900);
   localparam int FSK_MIN_CYC     = CLK_HZ / (2 * 3000);
   // ****************************************
   // Clock configuration codes
   // ****************************************
   localparam logic [1:0] CFG_00 = 2'h0;
   localparam logic [1:0] CFG_01 = 2'h1;
   localparam logic [1:0] CFG_10 = 2'h2;
   localparam logic [1:0] CFG_11 = 2'h3;
   typedef enum logic [2:0] {
      FMMC_CLK_EXT_3M6864 = 3'h0,
      FMMC_CLK_EXT_1M2288 = 3'h1,
      FMMC_CLK_INT_OSC    = 3'h2,
      FMMC_CLK_XTAL       = 3'h3,
      FMMC_CLK_EXT_4M     = 3'h4,
      FMMC_CLK_EXT_2M     = 3'h5
   } fmmc_clk_src_t;
   typedef enum logic [2:0] {
      FMMC_CLOCK_OUTPUT_PIN_OFF    = 3'h0,
      FMMC_CLOCK_OUTPUT_PIN_3M6864 = 3'h1,
      FMMC_CLOCK_OUTPUT_PIN_1M8432 = 3'h2,
      FMMC_CLOCK_OUTPUT_PIN_1M2288 = 3'h3,
      FMMC_CLOCK_OUTPUT_PIN_4M     = 3'h4
   } fmmc_clock_output_pin_t;
   // ****************************************
   // Path arbitration
   // ****************************************
   typedef enum logic [1:0] {
      FMMC_IDLE = 2'b00,
      FMMC_RX   = 2'b01,
      FMMC_TX   = 2'b10
   } fmmc_state_t;
   localparam logic [5:0] LINE_IDLE = 6'h00;
   localparam logic [5:0] MAN_HIGH  = 6'h1F;
   localparam logic [5:0] MAN_LOW   = 6'h21;
endpackage

//--- logic/fmmc_core.sv
`timescale 1ns/1ps
`default_nettype none
module fmmc_core #(
   parameter int OSC_START_CYCLES = fmmc_pkg::OSC_START_CYC
) (
   input  wire logic       clk,
   input  wire logic       reset,
   input  wire logic       spi_mode,
   input  wire logic       manchester_mode,
   input  wire logic       full_duplex,
   input  wire logic       rts_pin_n,
   input  wire logic       rts_bit,
   input  wire logic       host_tx_bit,
   input  wire logic       host_tx_valid,
   input  wire logic [7:0] host_tx_byte,
   input  wire logic       host_tx_write,
   input  wire logic       host_rx_read,
   input  wire logic [3:0] tx_watermark,
   input  wire logic [3:0] rx_watermark,
   input  wire logic [1:0] uart_tx_level,
   input  wire logic       line_receive_input,
   input  wire logic       filtered_receive_input,
   input  wire logic       use_filtered_input,
   input  wire logic       reference_enable_pin,
   input  wire logic       reference_powerdown_bit,
   input  wire logic       crystal_select_pin,
   input  wire logic       clock_config_high_pin,
   input  wire logic       clock_config_low_pin,
   output var  logic [5:0] line_drive_output,
   output var  logic       line_drive_high_z,
   output var  logic       carrier_detect_pin,
   output var  logic       irq_pin,
   output var  logic [7:0] link_condition,
   output var  logic       uart_rx_bit,
   output var  logic       uart_rx_oe,
   output var  logic [7:0] host_rx_byte,
   output var  logic [3:0] rx_level,
   output var  logic [3:0] tx_level,
   output var  logic       internal_reference_on,
   output var  logic [2:0] clock_source,
   output var  logic [2:0] clock_output_pin,
   output var  logic       crystal_on,
   output var  logic       tx_active,
   output var  logic       rx_active
);
   // ****************************************
   // Input synchronisers and arbitration
   // ****************************************
   logic [2:0] rx_sync_q;
   logic [2:0] rts_sync_q;
   wire  logic rx_in   = use_filtered_input ? filtered_receive_input : line_receive_input;
   wire  logic rx_s    = rx_sync_q[2];
   wire  logic rx_edge = rx_sync_q[2] != rx_sync_q[1];
   wire  logic rts_req = spi_mode ? rts_bit : !rts_sync_q[2];

   logic [fmmc_pkg::CNT_W-1:0] osc_cnt_q;
   wire  logic osc_ready = (osc_cnt_q == '0);
   wire  logic int_osc   = crystal_select_pin && clock_config_high_pin && !manchester_mode;

   fmmc_pkg::fmmc_state_t st_q, st_d;
   logic carrier_q;
   logic man_rx_busy_q;
   logic tx_busy;
   logic man_phase_q;
   logic osc_on_q;
   logic [7:0] txf_q [fmmc_pkg::FIFO_DEPTH];
   logic [7:0] rxf_q [fmmc_pkg::FIFO_DEPTH];
   logic [2:0] txw_q, txr_q, rxw_q, rxr_q;
   logic [3:0] txn_q, rxn_q;

   wire logic busy_rx = manchester_mode ? man_rx_busy_q : carrier_q;
   wire logic want_tx = manchester_mode ? (txn_q != 4'h0) : rts_req;
   always_comb begin
      st_d = st_q;
      unique case (st_q)
         fmmc_pkg::FMMC_IDLE: begin
            if (busy_rx)
               st_d = fmmc_pkg::FMMC_RX;
            else if (want_tx)
               st_d = fmmc_pkg::FMMC_TX;
         end
         fmmc_pkg::FMMC_RX: begin
            if (!busy_rx)
               st_d = fmmc_pkg::FMMC_IDLE;
         end
         fmmc_pkg::FMMC_TX: begin
            if (!want_tx && !tx_busy)
               st_d = fmmc_pkg::FMMC_IDLE;
         end
         default: st_d = fmmc_pkg::FMMC_IDLE;
      endcase
      if (!osc_ready)
         st_d = fmmc_pkg::FMMC_IDLE;
   end
   wire logic tx_en = (st_q == fmmc_pkg::FMMC_TX) && osc_ready;
   wire logic rx_en = osc_ready && ((st_q != fmmc_pkg::FMMC_TX) || full_duplex);

   // ****************************************
   // Transmit FIFO and bit source
   // ****************************************
   logic [7:0] txsh_q;
   logic [3:0] txbits_q;
   logic       fsk_bit_q;
   wire  logic fsk_done;
   wire  logic man_half_tick;
   wire  logic bit_tick = manchester_mode ? man_half_tick && man_phase_q : fsk_done;
   wire  logic use_fifo = spi_mode || manchester_mode;
   wire  logic tx_push  = host_tx_write && (txn_q != 4'(fmmc_pkg::FIFO_DEPTH)) && use_fifo;
   wire  logic tx_pop   = tx_en && use_fifo && (txbits_q == 4'h0) && (txn_q != 4'h0);
   assign tx_busy = txbits_q != 4'h0;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         txw_q    <= 3'h0;
         txr_q    <= 3'h0;
         txn_q    <= 4'h0;
         txsh_q   <= 8'h00;
         txbits_q <= 4'h0;
         fsk_bit_q <= 1'b1;
      end else begin
         if (tx_push) begin
            txf_q[txw_q] <= host_tx_byte;
            txw_q        <= txw_q + 3'h1;
         end
         if (tx_pop) begin
            txsh_q   <= txf_q[txr_q];
            txr_q    <= txr_q + 3'h1;
            txbits_q <= 4'h8;
         end else if (bit_tick && tx_busy) begin
            txsh_q   <= {1'b0, txsh_q[7:1]};
            txbits_q <= txbits_q - 4'h1;
         end
         txn_q <= txn_q + {3'h0, tx_push} - {3'h0, tx_pop};
         if (!use_fifo && host_tx_valid && tx_en)
            fsk_bit_q <= host_tx_bit;
         else if (use_fifo)
            fsk_bit_q <= tx_busy ? txsh_q[0] : 1'b1;
      end
   end

   // ****************************************
   // FSK modulator and Manchester encoder
   // ****************************************
   wire logic [5:0] sine_sample;
   fmmc_sine_mod u_mod (
      .clk         (clk),
      .reset       (reset),
      .enable      (tx_en && !manchester_mode),
      .tx_bit      (fsk_bit_q),
      .sample      (sine_sample),
      .period_done (fsk_done)
   );
   logic [fmmc_pkg::CNT_W-1:0] man_div_q;
   assign man_half_tick = man_div_q == fmmc_pkg::CNT_W'(fmmc_pkg::MAN_HALF_CYC - 1);
   // A zero sends low then high, a one sends high then low.
   wire logic man_level = txsh_q[0] ^ man_phase_q;

   // ****************************************
   // Receive: tone measurement, carrier, decoder
   // ****************************************
   logic [fmmc_pkg::CNT_W-1:0] half_q;
   logic [3:0] cd_cnt_q;
   logic       rx_bit_q;
   logic [7:0] rxsh_q;
   logic [2:0] rxbits_q;
   wire  logic tone_ok = (half_q >= fmmc_pkg::CNT_W'(fmmc_pkg::FSK_MIN_CYC))
                      && (half_q <= fmmc_pkg::CNT_W'(fmmc_pkg::FSK_MAX_CYC));
   wire  logic demod_bit = half_q > fmmc_pkg::CNT_W'(fmmc_pkg::FSK_SPLIT_CYC);
   wire  logic long_half = half_q > fmmc_pkg::CNT_W'(3 * fmmc_pkg::MAN_HALF_CYC / 2);
   wire  logic rx_push   = rx_en && man_rx_busy_q && rx_edge && long_half
                        && (rxbits_q == 3'h7) && (rxn_q != 4'(fmmc_pkg::FIFO_DEPTH));
   wire  logic rx_pop    = host_rx_read && (rxn_q != 4'h0);

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         rx_sync_q     <= 3'h0;
         rts_sync_q    <= 3'h7;
         osc_cnt_q     <= '0;
         st_q          <= fmmc_pkg::FMMC_IDLE;
         half_q        <= '0;
         cd_cnt_q      <= 4'h0;
         carrier_q     <= 1'b0;
         rx_bit_q      <= 1'b1;
         man_rx_busy_q <= 1'b0;
         rxsh_q        <= 8'h00;
         rxbits_q      <= 3'h0;
         osc_on_q      <= 1'b0;
         man_div_q     <= '0;
         man_phase_q   <= 1'b0;
         rxw_q         <= 3'h0;
         rxr_q         <= 3'h0;
         rxn_q         <= 4'h0;
      end else begin
         rx_sync_q  <= {rx_sync_q[1:0], rx_in};
         rts_sync_q <= {rts_sync_q[1:0], rts_pin_n};
         // Only a fresh enable starts the wait; leaving the oscillator cancels it.
         osc_on_q <= int_osc;
         if (int_osc && !osc_on_q)
            osc_cnt_q <= fmmc_pkg::CNT_W'(OSC_START_CYCLES);
         else if (int_osc && osc_cnt_q != '0)
            osc_cnt_q <= osc_cnt_q - 1'b1;
         else
            osc_cnt_q <= '0;
         st_q   <= st_d;
         half_q <= rx_edge ? '0 : half_q + 1'b1;
         if (rx_en && rx_edge && !manchester_mode) begin
            rx_bit_q <= demod_bit;
            if (tone_ok && cd_cnt_q != fmmc_pkg::CD_MAX)
               cd_cnt_q <= cd_cnt_q + 4'h1;
            else if (!tone_ok && cd_cnt_q != 4'h0)
               cd_cnt_q <= cd_cnt_q - 4'h1;
         end else if (!rx_en || half_q > fmmc_pkg::CNT_W'(fmmc_pkg::FSK_MAX_CYC)) begin
            cd_cnt_q <= 4'h0;
         end
         if (cd_cnt_q >= fmmc_pkg::CD_ON_CNT)
            carrier_q <= 1'b1;
         else if (cd_cnt_q == fmmc_pkg::CD_OFF_CNT)
            carrier_q <= 1'b0;
         man_rx_busy_q <= manchester_mode && rx_en
                       && (half_q < fmmc_pkg::CNT_W'(fmmc_pkg::MAN_RX_TIMEOUT));
         if (rx_en && man_rx_busy_q && rx_edge && long_half) begin
            rxsh_q   <= {!rx_s, rxsh_q[7:1]};
            rxbits_q <= rxbits_q + 3'h1;
         end
         man_div_q   <= (!tx_en || man_half_tick) ? '0 : man_div_q + 1'b1;
         man_phase_q <= !tx_en ? 1'b0 : (man_half_tick ? !man_phase_q : man_phase_q);
         if (rx_push) begin
            rxf_q[rxw_q] <= {!rx_s, rxsh_q[7:1]};
            rxw_q        <= rxw_q + 3'h1;
         end
         if (rx_pop)
            rxr_q <= rxr_q + 3'h1;
         rxn_q <= rxn_q + {3'h0, rx_push} - {3'h0, rx_pop};
      end
   end

   // ****************************************
   // Clock, reference and output registers
   // ****************************************
   wire logic [1:0] cfg = {clock_config_high_pin, clock_config_low_pin};
   fmmc_pkg::fmmc_clk_src_t src_d;
   fmmc_pkg::fmmc_clock_output_pin_t    clock_output_pin_d;
   always_comb begin
      src_d  = fmmc_pkg::FMMC_CLK_XTAL;
      clock_output_pin_d = fmmc_pkg::FMMC_CLOCK_OUTPUT_PIN_OFF;
      if (manchester_mode) begin
         if (crystal_select_pin)
            src_d = clock_config_high_pin ? fmmc_pkg::FMMC_CLK_EXT_2M
                                          : fmmc_pkg::FMMC_CLK_EXT_4M;
         else if (clock_config_high_pin)
            clock_output_pin_d = fmmc_pkg::FMMC_CLOCK_OUTPUT_PIN_4M;
      end else if (crystal_select_pin) begin
         unique case (cfg)
            fmmc_pkg::CFG_00: src_d = fmmc_pkg::FMMC_CLK_EXT_3M6864;
            fmmc_pkg::CFG_01: src_d = fmmc_pkg::FMMC_CLK_EXT_1M2288;
            fmmc_pkg::CFG_10: src_d = fmmc_pkg::FMMC_CLK_INT_OSC;
            fmmc_pkg::CFG_11: begin
               src_d  = fmmc_pkg::FMMC_CLK_INT_OSC;
               clock_output_pin_d = fmmc_pkg::FMMC_CLOCK_OUTPUT_PIN_1M2288;
            end
         endcase
      end else begin
         unique case (cfg)
            fmmc_pkg::CFG_00: clock_output_pin_d = fmmc_pkg::FMMC_CLOCK_OUTPUT_PIN_OFF;
            fmmc_pkg::CFG_01: clock_output_pin_d = fmmc_pkg::FMMC_CLOCK_OUTPUT_PIN_3M6864;
            fmmc_pkg::CFG_10: clock_output_pin_d = fmmc_pkg::FMMC_CLOCK_OUTPUT_PIN_1M8432;
            fmmc_pkg::CFG_11: clock_output_pin_d = fmmc_pkg::FMMC_CLOCK_OUTPUT_PIN_1M2288;
         endcase
      end
   end
   wire logic tx_low_man = (txn_q < {1'b0, uart_tx_level, 1'b0} + 4'h2);
   wire logic [7:0] cond_d = {rxn_q >= rx_watermark && rxn_q != 4'h0, 2'b00,
                              txn_q <= tx_watermark && tx_en, 2'b00, carrier_q, 1'b0};

   // Reset holds every other output at its power-down value; the clock source and crystal_on keep
   // following the pins because the crystal must stay controllable.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         line_drive_output     <= fmmc_pkg::LINE_IDLE;
         line_drive_high_z     <= 1'b1;
         carrier_detect_pin    <= 1'b0;
         irq_pin               <= 1'b0;
         link_condition        <= 8'h00;
         uart_rx_bit           <= 1'b1;
         uart_rx_oe            <= 1'b0;
         host_rx_byte          <= 8'h00;
         rx_level              <= 4'h0;
         tx_level              <= 4'h0;
         internal_reference_on <= 1'b0;
         clock_output_pin      <= 3'h0;
         tx_active             <= 1'b0;
         rx_active             <= 1'b0;
      end else begin
         line_drive_output <= !tx_en ? fmmc_pkg::LINE_IDLE
                            : manchester_mode ? (man_level ? fmmc_pkg::MAN_HIGH
                                                           : fmmc_pkg::MAN_LOW)
                            : sine_sample;
         line_drive_high_z <= 1'b0;
         carrier_detect_pin <= spi_mode ? 1'b0
                             : manchester_mode ? tx_low_man
                             : carrier_q;
         link_condition <= spi_mode ? (link_condition | cond_d) & cond_d : 8'h00;
         irq_pin        <= spi_mode && (cond_d != 8'h00);
         uart_rx_bit    <= manchester_mode ? (rxn_q != 4'h0 ? rxf_q[rxr_q][0] : 1'b1)
                                           : rx_bit_q;
         uart_rx_oe     <= !spi_mode;
         host_rx_byte   <= rxf_q[rxr_q];
         rx_level       <= rxn_q;
         tx_level       <= txn_q;
         internal_reference_on <= reference_enable_pin;
         clock_output_pin <= clock_output_pin_d;
         tx_active        <= tx_en;
         rx_active        <= rx_en && (busy_rx || !tx_en);
      end
   end

   // Clock selection has no reset: the pins stay in charge during power-down.
   always_ff @(posedge clk) begin
      clock_source <= src_d;
      crystal_on   <= !crystal_select_pin;
   end
endmodule
`default_nettype wire

//--- logic/fmmc_sine_mod.sv
`timescale 1ns/1ps
`default_nettype none
module fmmc_sine_mod (
   input  wire logic       clk,
   input  wire logic       reset,
   input  wire logic       enable,
   input  wire logic       tx_bit,
   output var  logic [5:0] sample,
   output var  logic       period_done
);
   // ****************************************
   // Sine table
   // ****************************************
   function automatic logic [5:0] sine_at(input logic [4:0] i);
      logic [5:0] v;
      v = 6'h00;
      unique case (i)
         5'h00: v = 6'h00; 5'h01: v = 6'h06; 5'h02: v = 6'h0C; 5'h03: v = 6'h12;
         5'h04: v = 6'h16; 5'h05: v = 6'h1A; 5'h06: v = 6'h1D; 5'h07: v = 6'h1F;
         5'h08: v = 6'h1F; 5'h09: v = 6'h1F; 5'h0A: v = 6'h1D; 5'h0B: v = 6'h1A;
         5'h0C: v = 6'h16; 5'h0D: v = 6'h12; 5'h0E: v = 6'h0C; 5'h0F: v = 6'h06;
         5'h10: v = 6'h00; 5'h11: v = 6'h3A; 5'h12: v = 6'h34; 5'h13: v = 6'h2E;
         5'h14: v = 6'h2A; 5'h15: v = 6'h26; 5'h16: v = 6'h23; 5'h17: v = 6'h21;
         5'h18: v = 6'h21; 5'h19: v = 6'h21; 5'h1A: v = 6'h23; 5'h1B: v = 6'h26;
         5'h1C: v = 6'h2A; 5'h1D: v = 6'h2E; 5'h1E: v = 6'h34; 5'h1F: v = 6'h3A;
      endcase
      return v;
   endfunction

   logic [fmmc_pkg::CNT_W-1:0] div_q;
   logic [4:0]                 idx_q;
   wire  logic [fmmc_pkg::CNT_W-1:0] step_lim;
   wire  logic                       step;

   // The index keeps its value across a bit change, so the tone never jumps.
   assign step_lim = tx_bit ? fmmc_pkg::CNT_W'(fmmc_pkg::MARK_STEP_CYC - 1)
                            : fmmc_pkg::CNT_W'(fmmc_pkg::SPACE_STEP_CYC - 1);
   assign step     = enable && (div_q >= step_lim);

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         div_q       <= '0;
         idx_q       <= 5'h00;
         sample      <= 6'h00;
         period_done <= 1'b0;
      end else begin
         div_q       <= (!enable || step) ? '0 : div_q + 1'b1;
         idx_q       <= !enable ? 5'h00 : (step ? idx_q + 5'h01 : idx_q);
         sample      <= enable ? sine_at(idx_q) : 6'h00;
         period_done <= step && (idx_q == 5'h1F);
      end
   end
endmodule
`default_nettype wire

//--- verification/fmmc_core_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module fmmc_core_assertions (
   input wire logic       clk,
   input wire logic       reset,
   input wire logic       spi_mode,
   input wire logic       manchester_mode,
   input wire logic       full_duplex,
   input wire logic       reference_enable_pin,
   input wire logic       crystal_select_pin,
   input wire logic       clock_config_high_pin,
   input wire logic       clock_config_low_pin,
   input wire logic       carrier_detect_pin,
   input wire logic       irq_pin,
   input wire logic [7:0] link_condition,
   input wire logic       internal_reference_on,
   input wire logic [2:0] clock_source,
   input wire logic [2:0] clock_output_pin,
   input wire logic       tx_active,
   input wire logic       rx_active
);
   // ********
   // Checks
   // ********
   wire logic [3:0] cfg_pins = {manchester_mode, crystal_select_pin,
                                clock_config_high_pin, clock_config_low_pin};
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   excl_paths_a: assert property (!full_duplex |-> !(tx_active && rx_active))
      else $error("transmit and receive paths active together");
   ref_select_a: assert property (!reset |=> internal_reference_on == $past(reference_enable_pin))
      else $error("reference choice does not follow the enable pin");
   carrier_irq_a: assert property (spi_mode && link_condition[1] |-> ##[0:2] irq_pin)
      else $error("carrier flag without interrupt");
   txlvl_irq_a: assert property (spi_mode && link_condition[4] |-> ##[0:2] irq_pin)
      else $error("transmit level flag without interrupt");
   rxrdy_irq_a: assert property (spi_mode && link_condition[7] |-> ##[0:2] irq_pin)
      else $error("data ready flag without interrupt");
   rx_priority_a: assert property (!spi_mode && !manchester_mode && !full_duplex
      && carrier_detect_pin && !tx_active |=> !tx_active)
      else $error("transmit started while carrier present");
   clock_output_pin_code_a: assert property (cfg_pins[3:2] == 2'h0 ##1 $stable(cfg_pins) [*2]
      |-> clock_output_pin == {1'b0, cfg_pins[1:0]})
      else $error("crystal clock output code wrong");
   clk_source_a: assert property (cfg_pins[3:2] == 2'h1 ##1 $stable(cfg_pins) [*2]
      |-> clock_source == (cfg_pins[1] ? 3'h2 : {2'h0, cfg_pins[0]}))
      else $error("clock source choice wrong");
   cover property (tx_active && !manchester_mode);
   cover property (tx_active && manchester_mode && spi_mode);
   cover property (rx_active && carrier_detect_pin);
endmodule
bind fmmc_core fmmc_core_assertions i_chk (.*);
`default_nettype wire

//--- verification/fmmc_line_model.sv
`timescale 1ns/1ps
`default_nettype none
// ********
// Bus tone source standing in for a remote transmitter.
// ********
module fmmc_line_model #(
   parameter int HALF_CYC = 8500
) (
   input  wire logic clk,
   input  wire logic enable,
   output var  logic line
);
   int cnt_q;
   // A quiet bus holds one level, so no edge can be counted as carrier.
   always_ff @(posedge clk) begin
      if (!enable) begin
         cnt_q <= 0;
         line  <= 1'b0;
      end else if (cnt_q == HALF_CYC - 1) begin
         cnt_q <= 0;
         line  <= ~line;
      end else begin
         cnt_q <= cnt_q + 1;
      end
   end
endmodule
`default_nettype wire

//--- verification/test_fsk_manchester_modem_core.sv
`timescale 1ns/1ps
`default_nettype none
module test_fsk_manchester_modem_core;
   logic       clk = 1'b0, reset = 1'b1, bus_on, spi_mode, manchester_mode, full_duplex;
   logic       rts_pin_n, rts_bit, host_tx_bit, host_tx_valid, host_tx_write, host_rx_read;
   logic       use_filtered_input, reference_enable_pin, reference_powerdown_bit;
   logic       crystal_select_pin, clock_config_high_pin, clock_config_low_pin;
   logic [7:0] host_tx_byte, link_condition, host_rx_byte;
   logic [3:0] tx_watermark, rx_watermark, rx_level, tx_level;
   logic [1:0] uart_tx_level;
   logic [5:0] line_drive_output, plan;
   logic [2:0] clock_source, clock_output_pin;
   logic       line_drive_high_z, carrier_detect_pin, irq_pin, uart_rx_bit, uart_rx_oe;
   logic       internal_reference_on, crystal_on, tx_active, rx_active;
   wire logic  line_receive_input, filtered_receive_input;
   int         mismatches = 0, samples_checked = 0, n;
   always #10 clk = ~clk;
   assign filtered_receive_input = line_receive_input;
   fmmc_line_model i_line (.clk, .enable(bus_on), .line(line_receive_input));
   fmmc_core #(.OSC_START_CYCLES(100)) i_dut (.*);
   // ********
   // Tasks
   // ********
   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] seen);
      samples_checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic tick();
      @(posedge clk);
      #1;
   endtask
   // Steps are timed change to change, so a partial first step is discarded.
   task automatic wait_change(output int k);
      logic [5:0] last;
      last = line_drive_output;
      k = 0;
      do begin
         tick();
         k++;
      end while (line_drive_output === last && k < 3000);
   endtask
   // Clock plan per {mode, crystal select, config high, config low}: {source, output}.
   function automatic logic [5:0] clk_plan(input logic [3:0] c);
      case (c) inside
         4'b00??: return {4'h6, c[1:0]};
         4'b010?: return {2'h0, c[0], 3'h0};
         4'b0110: return 6'h10;
         4'b0111: return 6'h13;
         4'b100?: return 6'h18;
         4'b101?: return 6'h1C;
         4'b110?: return 6'h20;
         default: return 6'h28;
      endcase
   endfunction
   task automatic complete_run();
      if (mismatches == 0 && samples_checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // ********
   // Tests
   // ********
   initial begin
      {bus_on, spi_mode, manchester_mode, full_duplex, rts_bit, host_tx_bit} = '0;
      {host_tx_valid, host_tx_write, host_rx_read, use_filtered_input} = '0;
      {crystal_select_pin, clock_config_high_pin, clock_config_low_pin} = '0;
      {rts_pin_n, reference_enable_pin, reference_powerdown_bit} = '1;
      {host_tx_byte, tx_watermark, rx_watermark, uart_tx_level} = '0;
      repeat (6) tick();
      check("high_z", 1, line_drive_high_z);
      check("drive", fmmc_pkg::LINE_IDLE, line_drive_output);
      check("clock_output_pin", fmmc_pkg::FMMC_CLOCK_OUTPUT_PIN_OFF, clock_output_pin);
      check("data_oe", 0, uart_rx_oe);
      check("ref_rst", 0, internal_reference_on);
      check("xtal_rst", 1, crystal_on);
      crystal_select_pin <= 1'b1;
      repeat (2) tick();
      check("xtal_off", 0, crystal_on);
      crystal_select_pin <= 1'b0;
      repeat (4) @(posedge clk);
      reset <= 1'b0;
      repeat (3) tick();
      check("ref_on", 1, internal_reference_on);
      {reference_enable_pin, reference_powerdown_bit} <= 2'h0;
      repeat (3) tick();
      check("ref_off", 0, internal_reference_on);
      for (int i = 0; i < 16; i++) begin
         {manchester_mode, crystal_select_pin, clock_config_high_pin, clock_config_low_pin} <= i[3:0];
         repeat (3) tick();
         plan = clk_plan(i[3:0]);
         check("clk_src", plan[5:3], clock_source);
         check("clk_out", plan[2:0], clock_output_pin);
      end
      {manchester_mode, crystal_select_pin, clock_config_high_pin, clock_config_low_pin} <= 4'h6;
      host_tx_valid <= 1'b1;
      rts_pin_n <= 1'b0;
      repeat (50) tick();
      check("osc_wait", 0, tx_active);
      for (n = 0; n < 80 && tx_active !== 1'b1; n++) tick();
      check("tx_on", 1, tx_active);
      check("rx_off", 0, rx_active);
      wait_change(n);
      wait_change(n);
      check("space_step", fmmc_pkg::SPACE_STEP_CYC, n);
      host_tx_bit <= 1'b1;
      repeat (3) wait_change(n);
      check("mark_step", fmmc_pkg::MARK_STEP_CYC, n);
      {rts_pin_n, spi_mode, manchester_mode, rts_bit} <= 4'hF;
      {tx_watermark, uart_tx_level} <= 6'h06;
      {host_tx_byte, host_tx_write} <= {8'hA5, 1'b1};
      tick();
      host_tx_write <= 1'b0;
      tick();
      for (n = 0; n < 20 && tx_active !== 1'b1; n++) tick();
      check("enc_on", 1, tx_active);
      wait_change(n);
      repeat (fmmc_pkg::MAN_HALF_CYC / 2) tick();
      check("tx_flag", 8'h10, link_condition);
      check("tx_irq", 1, irq_pin);
      for (int i = 0; i < 16; i++) begin
         plan = (((8'hA5 >> (i / 2)) ^ i) & 1) ? fmmc_pkg::MAN_HIGH : fmmc_pkg::MAN_LOW;
         check("half_bit", plan, line_drive_output);
         repeat (fmmc_pkg::MAN_HALF_CYC) tick();
      end
      {spi_mode, manchester_mode, rts_bit, bus_on} <= 4'h1;
      for (n = 0; n < 80000 && carrier_detect_pin !== 1'b1; n++) tick();
      check("carrier", 1, carrier_detect_pin);
      rts_pin_n <= 1'b0;
      repeat (20) tick();
      check("rx_keeps", 0, tx_active);
      check("rx_on", 1, rx_active);
      complete_run();
   end
   initial begin
      repeat (99000) @(posedge clk);
      mismatches++;
      complete_run();
   end
endmodule
`default_nettype wire
